//--- rtl/iopc_top.sv
// io port pin control: three ports, direction, drive select, output muxing
`timescale 1ns/1ps

// Notes on behaviour
// R01: without an enable term, direction bit 0 means input, 1 means output.
// R02: with an enable term, pin drives when direction bit or term is 1.
// R03: three-pin port keeps only the three low direction bits.
// R04: open-drain capable pins use open drain when drive bit is 1, else push-pull.
// R05: slew-capable pins use fast slew when drive bit is 1, else standard.
// R06: first 8-pin port: bits 7..4 open drain, bits 3..0 fast slew.
// R07: second 8-pin port: all eight drive bits select open drain, no slew.
// R08: three-pin port: bits 2..0 fast slew, bits 7..3 not applicable.
// R09: first port outputs group ab or bc macrocells; second port only group bc.
// R10: logic inputs from the 8-pin ports go through input macrocells.
// R11: second 8-pin port pins may be taken over as the jtag programming port.
// R12: three-pin port inputs feed the complex logic array directly.
// R13: three-pin port can output three decode-array chip selects, no macrocells used.
// R14: each external chip select is one product term with selectable polarity.
// R15: chip-select pin enable comes from its enable term or direction bit.
// R16: middle three-pin port pin as clock input feeds output macrocell flops.
// R17: top three-pin port pin high as chip-select input puts flash in standby.
// R18: deselect also idles port registers but never blocks logic arrays.
// R19: data-in read returns each pin's present level.
// R20: data-out write reaches a pin only when the logic array does not drive it.
// R21: all direction bits reset to 0, every pin starts as input.
// R22: host never sets direction 1 on a pin assigned as logic-array input.
// R23: drive-select reads back last write; not-applicable bits read 0.
module iopc_top
  import iopc_pkg::*;
#(
  parameter int WIDE_W = IOPC_WIDE_W,
  parameter int NARROW_W = IOPC_NARROW_W,
  parameter iopc_cfg_s CFG_B = '0,
  parameter iopc_cfg_s CFG_C = '0,
  parameter iopc_cfg_s CFG_D = '0,
  parameter logic B_USE_BC = 1'b0,
  parameter logic [2:0] ECS_ACTIVE_LOW = 3'h0,
  parameter logic D_CSI_EN = 1'b0,
  parameter logic D_LOGIC_CLOCK_INPUT_EN = 1'b0,
  parameter logic C_JTAG_EN = 1'b0
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire iopc_req_s req_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  input wire logic [7:0] macrocell_group_ab_out_i,
  input wire logic [7:0] macrocell_group_bc_out_i,
  input wire logic [7:0] port_b_oe_term_i,
  input wire logic [7:0] port_c_oe_term_i,
  input wire logic [2:0] port_d_oe_term_i,
  input wire logic [2:0] ext_chip_select_terms_i,
  input wire logic [7:0] input_macrocell_b_i,
  input wire logic [7:0] input_macrocell_c_i,
  input wire logic [7:0] jtag_out_i,
  input wire logic [7:0] jtag_oe_i,
  input wire logic [7:0] port_b_pin_i,
  input wire logic [7:0] port_c_pin_i,
  input wire logic [2:0] port_d_pin_i,
  output logic [7:0] port_b_pin_o,
  output logic [7:0] port_b_pin_oe_n_o,
  output logic [7:0] port_b_fast_slew_o,
  output logic [7:0] port_c_pin_o,
  output logic [7:0] port_c_pin_oe_n_o,
  output logic [2:0] port_d_pin_o,
  output logic [2:0] port_d_pin_oe_n_o,
  output logic [2:0] port_d_fast_slew_o,
  output logic [7:0] imc_in_b_o,
  output logic [7:0] imc_in_c_o,
  output logic [2:0] complex_logic_array_d_o,
  output logic [7:0] jtag_in_o,
  output logic logic_clock_input_o,
  output logic flash_standby_o,
  output logic regs_standby_o
);

  // the pin maps below are written for one 8-pin width and one 3-pin width only
  if (WIDE_W != IOPC_WIDE_W || NARROW_W != IOPC_NARROW_W) begin : g_width_check
    $error("iopc_top serves only 8-pin and 3-pin ports");
  end

  logic [7:0] dout_b_r, dout_c_r, dout_d_r;
  logic [7:0] dir_b_r, dir_c_r, dir_d_r;
  logic [7:0] drv_b_r, drv_c_r, drv_d_r;
  logic [7:0] rdata_r;
  logic rvalid_r;
  logic [7:0] b_pin_r, b_oe_n_r, b_slew_r, c_pin_r, c_oe_n_r;
  logic [2:0] d_pin_r, d_oe_n_r, d_slew_r;
  logic [7:0] imc_b_r, imc_c_r, jtag_in_r;
  logic [2:0] cla_d_r;
  logic logic_clock_input_r, csi_hi_r;

  // chip-select input high idles the register port, logic paths keep running
  wire csi_high = D_CSI_EN & port_d_pin_i[IOPC_D_CSI_PIN]; // R17
  wire bus_ok = req_i.sel & ~csi_high; // R18
  wire wr_en = bus_ok & req_i.wr;
  wire rd_en = bus_ok & req_i.rd;

  // port b source: logic array when configured, else data out
  wire [7:0] b_mc = B_USE_BC ? macrocell_group_bc_out_i : macrocell_group_ab_out_i; // R09
  wire [7:0] b_src = (CFG_B.logic_driven & b_mc) | (~CFG_B.logic_driven & dout_b_r); // R20
  wire [7:0] c_src = (CFG_C.logic_driven & macrocell_group_bc_out_i) | (~CFG_C.logic_driven & dout_c_r); // R09
  // external chip selects: one term each, polarity chosen per pin
  wire [2:0] ecs_val = ext_chip_select_terms_i ^ ECS_ACTIVE_LOW; // R14
  wire [2:0] d_src = (CFG_D.logic_driven[2:0] & ecs_val) | (~CFG_D.logic_driven[2:0] & dout_d_r[2:0]); // R13

  // direction resolution: dir OR defined enable term
  wire [7:0] b_drive = dir_b_r | (CFG_B.oe_term_def & port_b_oe_term_i); // R01 R02
  wire [7:0] c_drive_pre = dir_c_r | (CFG_C.oe_term_def & port_c_oe_term_i); // R01 R02
  wire [2:0] d_drive = (dir_d_r[2:0] & IOPC_D_DIR_MASK[2:0]) | (CFG_D.oe_term_def[2:0] & port_d_oe_term_i); // R03 R15

  // jtag takes over port c pins it claims
  wire [7:0] c_jt = C_JTAG_EN ? jtag_oe_i : 8'h00; // R11
  wire [7:0] c_val = (c_jt & jtag_out_i) | (~c_jt & c_src);
  wire [7:0] c_drive = c_jt | (~c_jt & c_drive_pre);

  // open drain: drive low only, release for a one
  wire [7:0] b_od = drv_b_r & IOPC_B_OD_MASK; // R04 R06
  wire [7:0] c_od = drv_c_r & IOPC_C_OD_MASK & ~c_jt; // R04 R07
  wire [7:0] b_oe_n_nxt = ~(b_drive & ~(b_od & b_src)); // R04
  wire [7:0] c_oe_n_nxt = ~(c_drive & ~(c_od & c_val)); // R04

  wire [7:0] rd_mux =
    (req_i.addr == IOPC_B_DATA_IN) ? port_b_pin_i : // R19
    (req_i.addr == IOPC_C_DATA_IN) ? port_c_pin_i :
    (req_i.addr == IOPC_D_DATA_IN) ? {5'h00, port_d_pin_i} :
    (req_i.addr == IOPC_B_DATA_OUT) ? dout_b_r :
    (req_i.addr == IOPC_C_DATA_OUT) ? dout_c_r :
    (req_i.addr == IOPC_D_DATA_OUT) ? dout_d_r :
    (req_i.addr == IOPC_B_DIRECTION) ? dir_b_r :
    (req_i.addr == IOPC_C_DIRECTION) ? dir_c_r :
    (req_i.addr == IOPC_D_DIRECTION) ? dir_d_r :
    (req_i.addr == IOPC_B_DRIVE_SEL) ? drv_b_r :
    (req_i.addr == IOPC_C_DRIVE_SEL) ? drv_c_r :
    (req_i.addr == IOPC_D_DRIVE_SEL) ? drv_d_r : 8'h00; // R23

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      dout_b_r <= IOPC_REG_RESET;
      dout_c_r <= IOPC_REG_RESET;
      dout_d_r <= IOPC_REG_RESET;
      dir_b_r <= IOPC_REG_RESET; // R21
      dir_c_r <= IOPC_REG_RESET;
      dir_d_r <= IOPC_REG_RESET;
      drv_b_r <= IOPC_REG_RESET;
      drv_c_r <= IOPC_REG_RESET;
      drv_d_r <= IOPC_REG_RESET;
    end else if (wr_en) begin
      case (req_i.addr)
        IOPC_B_DATA_OUT: dout_b_r <= req_i.wdata;
        IOPC_C_DATA_OUT: dout_c_r <= req_i.wdata;
        IOPC_D_DATA_OUT: dout_d_r <= req_i.wdata & IOPC_D_DIR_MASK;
        IOPC_B_DIRECTION: dir_b_r <= req_i.wdata;
        IOPC_C_DIRECTION: dir_c_r <= req_i.wdata;
        IOPC_D_DIRECTION: dir_d_r <= req_i.wdata & IOPC_D_DIR_MASK; // R03
        IOPC_B_DRIVE_SEL: drv_b_r <= req_i.wdata;
        IOPC_C_DRIVE_SEL: drv_c_r <= req_i.wdata;
        IOPC_D_DRIVE_SEL: drv_d_r <= req_i.wdata & IOPC_D_SLEW_MASK; // R08 R23
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r <= rd_en ? rd_mux : 8'h00;
      rvalid_r <= rd_en;
    end
  end

  // pin-facing outputs registered so every port leaves a flop
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      b_pin_r <= 8'h00;
      b_oe_n_r <= 8'hFF;
      b_slew_r <= 8'h00;
      c_pin_r <= 8'h00;
      c_oe_n_r <= 8'hFF;
      d_pin_r <= 3'h0;
      d_oe_n_r <= 3'h7;
      d_slew_r <= 3'h0;
      imc_b_r <= 8'h00;
      imc_c_r <= 8'h00;
      cla_d_r <= 3'h0;
      jtag_in_r <= 8'h00;
      logic_clock_input_r <= 1'b0;
      csi_hi_r <= 1'b0;
    end else begin
      b_pin_r <= b_src;
      b_oe_n_r <= b_oe_n_nxt; // R01 R02
      b_slew_r <= drv_b_r & IOPC_B_SLEW_MASK; // R05 R06
      c_pin_r <= c_val;
      c_oe_n_r <= c_oe_n_nxt; // R07
      d_pin_r <= d_src;
      d_oe_n_r <= ~d_drive; // R15
      d_slew_r <= drv_d_r[2:0] & IOPC_D_SLEW_MASK[2:0]; // R05 R08
      imc_b_r <= input_macrocell_b_i; // R10
      imc_c_r <= input_macrocell_c_i; // R10
      cla_d_r <= port_d_pin_i; // R12
      jtag_in_r <= C_JTAG_EN ? port_c_pin_i : 8'h00; // R11
      logic_clock_input_r <= D_LOGIC_CLOCK_INPUT_EN & port_d_pin_i[IOPC_D_CLK_PIN]; // R16
      csi_hi_r <= csi_high; // R17 R18
    end
  end

  assign rdata_o = rdata_r;
  assign rvalid_o = rvalid_r;
  assign port_b_pin_o = b_pin_r;
  assign port_b_pin_oe_n_o = b_oe_n_r;
  assign port_b_fast_slew_o = b_slew_r;
  assign port_c_pin_o = c_pin_r;
  assign port_c_pin_oe_n_o = c_oe_n_r;
  assign port_d_pin_o = d_pin_r;
  assign port_d_pin_oe_n_o = d_oe_n_r;
  assign port_d_fast_slew_o = d_slew_r;
  assign imc_in_b_o = imc_b_r;
  assign imc_in_c_o = imc_c_r;
  assign complex_logic_array_d_o = cla_d_r;
  assign jtag_in_o = jtag_in_r;
  assign logic_clock_input_o = logic_clock_input_r;
  assign flash_standby_o = csi_hi_r;
  assign regs_standby_o = csi_hi_r;

  // the host keeps logic-input pins at direction 0; not checked here, it is theirs
  // R22

  dir_reset_a: assert property (@(posedge clk_i) !reset_n_i |=> dir_b_r == 8'h00 && dir_d_r == 8'h00) // R21
    else $error("direction not cleared by reset");
  dir_d_high_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) dir_d_r[7:3] == 5'h00) // R03
    else $error("port d upper direction bits set");
  drv_d_na_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) drv_d_r[7:3] == 5'h00) // R08
    else $error("port d na drive bits set");
  b_drive_or_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R02
    (b_drive[0] && !b_od[0]) |=> !port_b_pin_oe_n_o[0])
    else $error("port b pin0 not driven");
  b_slew_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R06
    1'b1 |=> port_b_fast_slew_o == ($past(drv_b_r) & IOPC_B_SLEW_MASK))
    else $error("port b slew mismatch");
  d_oe_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R15
    1'b1 |=> port_d_pin_oe_n_o == ~($past(dir_d_r[2:0]) | (CFG_D.oe_term_def[2:0] & $past(port_d_oe_term_i))))
    else $error("port d enable mismatch");
  rd_in_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R19
    (rd_en && req_i.addr == IOPC_B_DATA_IN) |=> rvalid_o && rdata_o == $past(port_b_pin_i))
    else $error("data in read wrong");
  csi_block_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R18
    (csi_high && req_i.sel && req_i.rd) |=> !rvalid_o)
    else $error("read served while deselected");
  c_od_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R07
    (c_drive[0] && c_od[0] && c_val[0]) |=> port_c_pin_oe_n_o[0])
    else $error("open drain drove high");
  b_od_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R04
    (drv_b_r[7] && b_src[7]) |=> port_b_pin_oe_n_o[7])
    else $error("port b open drain drove high");

  // pins owned by the logic arrays or the jtag engine ignore the host's data out
  jtag_own_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R11
    (C_JTAG_EN && jtag_oe_i[0]) |=> !port_c_pin_oe_n_o[0] && port_c_pin_o[0] == $past(jtag_out_i[0]))
    else $error("jtag pin not driven");
  macrocell_c_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R09
    (CFG_C.logic_driven[7] && !(C_JTAG_EN && jtag_oe_i[7])) |=>
    port_c_pin_o[7] == $past(macrocell_group_bc_out_i[7]))
    else $error("port c macrocell not routed");
  ecs_polarity_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R14
    CFG_D.logic_driven[0] |=> port_d_pin_o[0] == ($past(ext_chip_select_terms_i[0]) ^ ECS_ACTIVE_LOW[0]))
    else $error("chip select polarity wrong");
  data_out_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R20
    !CFG_B.logic_driven[0] |=> port_b_pin_o[0] == $past(dout_b_r[0]))
    else $error("data out did not reach port b");

  // pass-through paths: one flop of lag, nothing gated by the chip-select input
  clock_in_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R16
    1'b1 |=> logic_clock_input_o == (D_LOGIC_CLOCK_INPUT_EN && $past(port_d_pin_i[IOPC_D_CLK_PIN])))
    else $error("clock input not passed");
  standby_follow_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R17
    1'b1 |=> flash_standby_o == (D_CSI_EN && $past(port_d_pin_i[IOPC_D_CSI_PIN])) && regs_standby_o == flash_standby_o)
    else $error("standby does not follow chip select");
  imc_pass_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R10
    1'b1 |=> imc_in_b_o == $past(input_macrocell_b_i) && imc_in_c_o == $past(input_macrocell_c_i))
    else $error("input macrocell not passed");
  direct_input_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R12
    1'b1 |=> complex_logic_array_d_o == $past(port_d_pin_i))
    else $error("port d input not direct");
  d_slew_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R08
    1'b1 |=> port_d_fast_slew_o == $past(drv_d_r[2:0]))
    else $error("port d slew mismatch");

  // deselect must freeze the register port and nothing else
  write_block_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R18
    (csi_high && req_i.sel && req_i.wr) |=> $stable(drv_b_r) && $stable(dir_b_r))
    else $error("write taken while deselected");
  rvalid_follow_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R18
    1'b1 |=> rvalid_o == $past(rd_en))
    else $error("read answer without accepted read");
  rd_na_zero_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R23
    (rd_en && req_i.addr == IOPC_D_DRIVE_SEL) |=> rdata_o[7:3] == 5'h00)
    else $error("na drive bits read nonzero");

  wr_cov_c: cover property (@(posedge clk_i) wr_en && req_i.addr == IOPC_B_DIRECTION);
  rd_cov_c: cover property (@(posedge clk_i) rd_en && req_i.addr == IOPC_D_DRIVE_SEL);
  csi_cov_c: cover property (@(posedge clk_i) csi_high && req_i.sel);
  od_cov_c: cover property (@(posedge clk_i) |c_od);
  ecs_cov_c: cover property (@(posedge clk_i) port_d_oe_term_i[0] && CFG_D.oe_term_def[0]);

endmodule : iopc_top

//--- rtl/iopc_pkg.sv
// package for the io port pin control block: register map, field layout, carriers
package iopc_pkg;

  localparam int IOPC_ADDR_W = 4;
  localparam int IOPC_WIDE_W = 8;
  localparam int IOPC_NARROW_W = 3;

  // register indices on the host register port
  localparam logic [3:0] IOPC_B_DATA_IN = 4'h0;
  localparam logic [3:0] IOPC_C_DATA_IN = 4'h1;
  localparam logic [3:0] IOPC_D_DATA_IN = 4'h2;
  localparam logic [3:0] IOPC_B_DATA_OUT = 4'h3;
  localparam logic [3:0] IOPC_C_DATA_OUT = 4'h4;
  localparam logic [3:0] IOPC_D_DATA_OUT = 4'h5;
  localparam logic [3:0] IOPC_B_DIRECTION = 4'h6;
  localparam logic [3:0] IOPC_C_DIRECTION = 4'h7;
  localparam logic [3:0] IOPC_D_DIRECTION = 4'h8;
  localparam logic [3:0] IOPC_B_DRIVE_SEL = 4'h9;
  localparam logic [3:0] IOPC_C_DRIVE_SEL = 4'hA;
  localparam logic [3:0] IOPC_D_DRIVE_SEL = 4'hB;

  localparam logic [7:0] IOPC_REG_RESET = 8'h00;
  // drive-select field layout
  localparam logic [7:0] IOPC_B_OD_MASK = 8'hF0;
  localparam logic [7:0] IOPC_B_SLEW_MASK = 8'h0F;
  localparam logic [7:0] IOPC_C_OD_MASK = 8'hFF;
  localparam logic [7:0] IOPC_D_SLEW_MASK = 8'h07;
  localparam logic [7:0] IOPC_D_DIR_MASK = 8'h07;
  localparam int IOPC_B_OD_LSB = 4;
  localparam int IOPC_D_CLK_PIN = 1;
  localparam int IOPC_D_CSI_PIN = 2;

  // register port request from the host bus
  typedef struct packed {
    logic sel;
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } iopc_req_s;

  // per-port configuration fixed at build time, as the logic configuration tool would set it
  typedef struct packed {
    logic [7:0] oe_term_def;
    logic [7:0] logic_driven;
  } iopc_cfg_s;

endpackage : iopc_pkg

//--- testbench/iopc_ext_dev.sv
// external devices on the port pins: resolve each pin level from block drive and far side
`timescale 1ns/1ps
module iopc_ext_dev #(
  parameter int W = 8
) (
  input wire logic [W-1:0] pin_o,
  input wire logic [W-1:0] oe_n,
  input wire logic [W-1:0] ext,
  output logic [W-1:0] level
);
  // a released line follows the far side; the far side never fights a driving pin
  assign level = (~oe_n & pin_o) | (oe_n & ext);
endmodule : iopc_ext_dev

//--- testbench/test_io_port_pin_control.sv
// self-checking bench for the io port pin control block
`timescale 1ns/1ps
module test_io_port_pin_control;
  import iopc_pkg::*;
  localparam iopc_cfg_s CFG_B = '{oe_term_def: 8'h0F, logic_driven: 8'h00};
  localparam iopc_cfg_s CFG_C = '{oe_term_def: 8'h00, logic_driven: 8'hF0};
  localparam iopc_cfg_s CFG_D = '{oe_term_def: 8'h01, logic_driven: 8'h01};
  localparam logic [2:0] ECS_LOW = 3'h1;
  localparam logic JT_ON = 1'b1;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  iopc_req_s req_i = '0;
  logic [7:0] mab = '0, mbc = '0, oe_b = '0, oe_c = '0, imb = '0, imcc = '0, ext_b, ext_c, pb_i, pc_i;
  logic [2:0] ext_d, pd_i, pd_o, pd_oe_n, pd_slew, cla_d;
  logic [7:0] rdata_o, pb_o, pb_oe_n, pb_slew, pc_o, pc_oe_n, imc_b, imc_c, e, v, d, t;
  logic rvalid_o, logic_clock_input, fl_sb, rg_sb;
  logic [7:0] jt_o = '0, jt_oe = '0, jt_in;
  logic [2:0] oe_d = '0, ecs_t = '0;
  logic [7:0] ds [3];
  logic [7:0] exp_q [$];
  logic [31:0] st = 32'h2D18B033;
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;

  iopc_top #(.CFG_B(CFG_B), .CFG_C(CFG_C), .CFG_D(CFG_D), .ECS_ACTIVE_LOW(ECS_LOW), .D_CSI_EN(1'b1),
    .D_LOGIC_CLOCK_INPUT_EN(1'b1), .C_JTAG_EN(JT_ON)) DUT (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .req_i(req_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .macrocell_group_ab_out_i(mab),
    .macrocell_group_bc_out_i(mbc), .port_b_oe_term_i(oe_b), .port_c_oe_term_i(oe_c),
    .port_d_oe_term_i(oe_d), .ext_chip_select_terms_i(ecs_t), .input_macrocell_b_i(imb),
    .input_macrocell_c_i(imcc), .jtag_out_i(jt_o), .jtag_oe_i(jt_oe), .port_b_pin_i(pb_i),
    .port_c_pin_i(pc_i), .port_d_pin_i(pd_i), .port_b_pin_o(pb_o), .port_b_pin_oe_n_o(pb_oe_n),
    .port_b_fast_slew_o(pb_slew), .port_c_pin_o(pc_o), .port_c_pin_oe_n_o(pc_oe_n), .port_d_pin_o(pd_o),
    .port_d_pin_oe_n_o(pd_oe_n), .port_d_fast_slew_o(pd_slew), .imc_in_b_o(imc_b), .imc_in_c_o(imc_c),
    .complex_logic_array_d_o(cla_d), .jtag_in_o(jt_in), .logic_clock_input_o(logic_clock_input), .flash_standby_o(fl_sb),
    .regs_standby_o(rg_sb));
  iopc_ext_dev dev_b (.pin_o(pb_o), .oe_n(pb_oe_n), .ext(ext_b), .level(pb_i));
  iopc_ext_dev dev_c (.pin_o(pc_o), .oe_n(pc_oe_n), .ext(ext_c), .level(pc_i));
  iopc_ext_dev #(.W(3)) dev_d (.pin_o(pd_o), .oe_n(pd_oe_n), .ext(ext_d), .level(pd_i));

  always #20 clk_i = ~clk_i;

  function automatic logic [7:0] rnd();
    st ^= st << 13;
    st ^= st >> 17;
    st ^= st << 5;
    return st[7:0];
  endfunction : rnd

  task automatic chk_pin(input string n, input logic [7:0] x, input logic [7:0] s);
    n_compared++;
    if (s !== x) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask : chk_pin

  task automatic chk_rd(input logic [7:0] s);
    if (exp_q.size() == 0) chk_pin("unexpected rvalid", 8'h00, 8'h01);
    else chk_pin("rdata", exp_q.pop_front(), s);
  endtask : chk_rd

  // a read is only answered while the chip-select input is low
  task automatic acc(input logic wr, input logic [3:0] a, input logic [7:0] wd, input logic [7:0] x);
    @(negedge clk_i);
    req_i <= '{sel: 1'b1, wr: wr, rd: ~wr, addr: a, wdata: wd};
    if (!wr && !ext_d[2]) exp_q.push_back(x);
  endtask : acc

  task automatic idle(input int n);
    @(negedge clk_i);
    req_i <= '0;
    repeat (n) @(negedge clk_i);
  endtask : idle

  task automatic give_verdict;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict

  always @(negedge clk_i) if (rvalid_o === 1'b1) chk_rd(rdata_o);

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      give_verdict();
    end
  end

  initial begin
    ext_b = rnd();
    ext_c = rnd();
    ext_d = 3'(rnd()) & 3'h3;
    repeat (8) @(negedge clk_i);
    reset_n_i <= 1'b1;
    acc(1'b0, IOPC_B_DATA_IN, 8'h00, ext_b);
    acc(1'b0, IOPC_C_DATA_IN, 8'h00, ext_c);
    acc(1'b0, IOPC_D_DATA_IN, 8'h00, {5'h00, ext_d});
    for (int a = 3; a < 12; a++) acc(1'b0, 4'(a), 8'h00, IOPC_REG_RESET);
    acc(1'b0, 4'hC, 8'h00, 8'h00);
    for (int i = 0; i < 3; i++) begin
      ds[i] = rnd();
      acc(1'b1, 4'(IOPC_B_DRIVE_SEL + i), ds[i], 8'h00);
      acc(1'b0, 4'(IOPC_B_DRIVE_SEL + i), 8'h00, (i == 2) ? ds[i] & IOPC_D_SLEW_MASK : ds[i]);
    end
    idle(2);
    chk_pin("fast slew b", ds[0] & IOPC_B_SLEW_MASK, pb_slew);
    chk_pin("fast slew d", {5'h00, ds[2][2:0]}, {5'h00, pd_slew});
    acc(1'b1, IOPC_B_DRIVE_SEL, 8'h00, 8'h00);
    repeat (4) begin
      v = rnd();
      d = rnd();
      t = rnd();
      acc(1'b1, IOPC_B_DATA_OUT, v, 8'h00);
      acc(1'b1, IOPC_B_DIRECTION, d, 8'h00);
      oe_b <= t;
      idle(3);
      e = ~(d | (t & CFG_B.oe_term_def));
      chk_pin("oe_n b", e, pb_oe_n);
      chk_pin("driven b", v & ~e, pb_o & ~e);
      acc(1'b0, IOPC_B_DATA_IN, 8'h00, (v & ~e) | (ext_b & e));
      idle(2);
    end
    oe_b <= 8'h00;
    acc(1'b1, IOPC_B_DRIVE_SEL, 8'hF0, 8'h00);
    acc(1'b1, IOPC_C_DRIVE_SEL, 8'hFF, 8'h00);
    acc(1'b1, IOPC_B_DIRECTION, 8'hFF, 8'h00);
    acc(1'b1, IOPC_C_DIRECTION, 8'hFF, 8'h00);
    acc(1'b1, IOPC_B_DATA_OUT, 8'hFF, 8'h00);
    acc(1'b1, IOPC_C_DATA_OUT, 8'h0F, 8'h00);
    idle(3);
    chk_pin("open drain b", 8'hF0, pb_oe_n);
    chk_pin("open drain c", 8'h0F, pc_oe_n);
    // all direction bits are kept for an 8-bit port, three for port d
    acc(1'b1, IOPC_D_DIRECTION, 8'hFF, 8'h00);
    acc(1'b0, IOPC_D_DIRECTION, 8'h00, IOPC_D_DIR_MASK);
    acc(1'b1, IOPC_D_DIRECTION, 8'h00, 8'h00);
    imb <= rnd();
    imcc <= rnd();
    idle(2);
    chk_pin("imc b", imb, imc_b);
    chk_pin("imc c", imcc, imc_c);
    chk_pin("direct d", {5'h00, pd_i}, {5'h00, cla_d});
    chk_pin("clock in", {7'h00, pd_i[1]}, {7'h00, logic_clock_input});
    ext_d[2] <= 1'b1;
    idle(2);
    chk_pin("standby", 8'h03, {6'h00, fl_sb, rg_sb});
    acc(1'b1, IOPC_B_DRIVE_SEL, 8'h55, 8'h00);
    acc(1'b0, IOPC_B_DRIVE_SEL, 8'h00, 8'h00);
    imb <= ~imb;
    idle(2);
    chk_pin("imc live", imb, imc_b);
    ext_d[2] <= 1'b0;
    idle(2);
    acc(1'b0, IOPC_B_DRIVE_SEL, 8'h00, 8'hF0);
    idle(3);
    // upper port c pins belong to the bc macrocells, pin 0 of port d is an active-low chip select
    v = rnd();
    mbc <= rnd();
    oe_d <= 3'(rnd());
    ecs_t <= 3'(rnd());
    jt_o <= rnd();
    jt_oe <= rnd();
    acc(1'b1, IOPC_C_DATA_OUT, v, 8'h00);
    idle(3);
    e = ((mbc & CFG_C.logic_driven) | (v & ~CFG_C.logic_driven)) & ~jt_oe;
    chk_pin("port c value", e | (jt_o & jt_oe), pc_o);
    chk_pin("jtag enable", 8'h00, pc_oe_n & jt_oe);
    chk_pin("jtag in", pc_i, jt_in);
    chk_pin("ecs enable", {5'h00, 2'b11, ~oe_d[0]}, {5'h00, pd_oe_n});
    chk_pin("ecs value", {7'h00, ~ecs_t[0]}, {5'h00, pd_o});
    chk_pin("reads left", 8'h00, 8'(exp_q.size()));
    give_verdict();
  end
endmodule : test_io_port_pin_control
